// ==== logic/usbec_ctrl.sv ====
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps

// Operation
// - eye_test_enable set runs the eye-pattern test; clear keeps it off.
// - output_enable_monitor set shows when D+/D- are driven; clear keeps it inactive.
// - halt_when_idle set halts the block while the chip is idle.
// - auto_sleep_suspend set suspends the block whenever the chip sleeps.
// - auto_sleep_suspend clear: only software_suspend suspends and stops the 48 MHz clock.
// - bits 31 to 8 of config and endpoint registers always read zero.
// - host mode endpoint 0 low_speed_direct set allows direct low-speed, else PRE via hub.
// - host mode endpoint 0 nak_retry_disable clear retries NAKed transactions in hardware.
// - with transmit and receive on, control_transfer_disable refuses SETUP transfers.
// - endpoint accepts received data only while endpoint_receive_enable is set.
// - endpoint transmits only while endpoint_transmit_enable is set.
// - endpoint_stalled reads one once the endpoint has been stalled.
// - handshakes are sent only while endpoint_handshake_enable is set.
// - sixteen identical endpoint registers, each with its own bits.
module usbec_ctrl
    import usbec_pkg::*;
(
    input  wire logic                   CORE_CLK,
    input  wire logic                   RST_B,
    input  wire logic [AXI_ADDR_W-1:0]  AWADDR,
    input  wire logic                   AWVALID,
    output logic                        AWREADY,
    input  wire logic [31:0]            WDATA,
    input  wire logic [3:0]             WSTRB,
    input  wire logic                   WVALID,
    output logic                        WREADY,
    output logic [1:0]                  BRESP,
    output logic                        BVALID,
    input  wire logic                   BREADY,
    input  wire logic [AXI_ADDR_W-1:0]  ARADDR,
    input  wire logic                   ARVALID,
    output logic                        ARREADY,
    output logic [31:0]                 RDATA,
    output logic [1:0]                  RRESP,
    output logic                        RVALID,
    input  wire logic                   RREADY,
    input  wire usbec_tok_t             TOKEN,
    input  wire logic [NUM_EP-1:0]      STALL_SET,
    input  wire logic                   LINE_DRIVE,
    input  wire logic                   HOST_MODE,
    input  wire logic                   NAK_SEEN,
    input  wire logic                   CHIP_IDLE,
    input  wire logic                   CHIP_SLEEP,
    output logic                        TOK_ACCEPT,
    output logic                        TOK_REFUSE,
    output logic                        TOK_HANDSHAKE,
    output logic                        NAK_RETRY,
    output logic                        LOW_SPEED_DIRECT,
    output logic                        PRE_PID_REQ,
    output logic                        EYE_TEST_RUN,
    output logic                        OE_MON_B,
    output logic                        MODULE_HALT,
    output logic                        USB_SUSPEND,
    output logic                        CLK48_EN,
    output logic                        IRQ
);

    // ==========================================
    // state
    usbec_state_t              q;
    usbec_state_t              d;
    logic                      wr_fire;
    logic [AXI_ADDR_W-1:0]     wr_addr;
    logic [7:0]                wr_data;
    logic                      wr_lane0;
    logic [NUM_EP-1:0][7:0]    ep_nxt;
    logic [NUM_EP-1:0]         ep_hit;
    logic [7:0]                tok_ep;
    logic                      tok_ok;
    logic [IRQ_W-1:0]          irq_evt;
    logic [31:0]               rd_val;
    logic                      rd_map;
    logic                      susp_now;

    // ==========================================
    // write channel capture: address and data in either order
    always_comb begin
        AWREADY  = !q.aw_got && !q.bvalid;
        WREADY   = !q.w_got && !q.bvalid;
        wr_addr  = q.aw_got ? q.awaddr : AWADDR;
        wr_data  = q.w_got ? q.wdata : WDATA[7:0];
        wr_lane0 = q.w_got ? q.wstrb0 : WSTRB[0];
        wr_fire  = !q.bvalid && (q.aw_got || AWVALID) && (q.w_got || WVALID);
    end

    // ==========================================
    // per endpoint next value: software write, then hardware stall set on top
    for (genvar gi = 0; gi < NUM_EP; gi++) begin : g_ep
        assign ep_hit[gi] = wr_fire && wr_lane0
                            && (wr_addr == 8'(OFS_EP_BASE + 8'(4 * gi)));
        always_comb begin
            ep_nxt[gi] = ep_hit[gi] ? (wr_data & EP_MASK) : q.ep[gi];
            ep_nxt[gi][EP_STAL_BIT] = ep_nxt[gi][EP_STAL_BIT] | STALL_SET[gi];
        end
    end

    // ==========================================
    // read decode, upper 24 bits always zero
    always_comb begin
        rd_map = 1'b1;
        rd_val = 32'h0000_0000;
        if (ARADDR[7:6] == EP_PAGE && ARADDR[1:0] == 2'h0) begin
            rd_val = {24'h00_0000, q.ep[ARADDR[5:2]]};
        end else begin
            case (ARADDR)
                OFS_CONFIG:  rd_val = {24'h00_0000, q.cfg};
                OFS_POWER:   rd_val = {30'h0, q.sw_susp, 1'b0};
                OFS_IRQ_STS: rd_val = {29'h0, q.irq_sts};
                OFS_IRQ_EN:  rd_val = {29'h0, q.irq_en};
                OFS_IRQ_CLR: rd_val = 32'h0000_0000;
                default:     rd_map = 1'b0;
            endcase
        end
    end

    // ==========================================
    // token decision against the addressed endpoint
    always_comb begin
        tok_ep = q.ep[TOKEN.ep];
        case (TOKEN.kind)
            USBEC_TOK_OUT:   tok_ok = tok_ep[EP_RXEN_BIT];
            USBEC_TOK_IN:    tok_ok = tok_ep[EP_TXEN_BIT];
            USBEC_TOK_SETUP: tok_ok = tok_ep[EP_RXEN_BIT]
                                      && !(tok_ep[EP_TXEN_BIT] && tok_ep[EP_RXEN_BIT]
                                           && tok_ep[EP_CDIS_BIT]);
            default:         tok_ok = 1'b0;
        endcase
        tok_ok = tok_ok && !tok_ep[EP_STAL_BIT] && !q.halted && !q.susp;
    end

    // suspend request: software bit always, sleep only when auto enabled
    assign susp_now = q.sw_susp || (q.cfg[CFG_ASUS_BIT] && CHIP_SLEEP);
    assign irq_evt  = {susp_now && !q.susp,
                       TOKEN.valid && !tok_ok,
                       |STALL_SET};

    // ==========================================
    // next state
    always_comb begin
        d    = q;
        d.ep = ep_nxt;
        // write channel holding and response
        if (AWVALID && AWREADY && !wr_fire) begin
            d.aw_got = 1'b1;
            d.awaddr = AWADDR;
        end
        if (WVALID && WREADY && !wr_fire) begin
            d.w_got  = 1'b1;
            d.wdata  = WDATA[7:0];
            d.wstrb0 = WSTRB[0];
        end
        if (wr_fire) begin
            d.aw_got = 1'b0;
            d.w_got  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = (wr_addr[7:6] == EP_PAGE && wr_addr[1:0] == 2'h0)
                       || wr_addr == OFS_CONFIG || wr_addr == OFS_POWER
                       || wr_addr == OFS_IRQ_STS || wr_addr == OFS_IRQ_EN
                       || wr_addr == OFS_IRQ_CLR ? RESP_OKAY : RESP_SLVERR;
            if (wr_lane0) begin
                case (wr_addr)
                    OFS_CONFIG: d.cfg = wr_data & CFG_MASK;
                    OFS_POWER:  d.sw_susp = wr_data[PWR_SUSP_BIT];
                    OFS_IRQ_EN: d.irq_en = wr_data[IRQ_W-1:0];
                    OFS_IRQ_CLR: d.irq_sts = q.irq_sts & ~wr_data[IRQ_W-1:0];
                    default: d.cfg = q.cfg;
                endcase
            end
        end else if (q.bvalid && BREADY) begin
            d.bvalid = 1'b0;
        end
        // sticky events: a set in the clearing cycle wins
        d.irq_sts = d.irq_sts | irq_evt;
        // read channel
        if (ARVALID && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rdata  = rd_val;
            d.rresp  = rd_map ? RESP_OKAY : RESP_SLVERR;
        end else if (q.rvalid && RREADY) begin
            d.rvalid = 1'b0;
        end
        // token answers, one-cycle pulses
        d.tok_acc   = TOKEN.valid && tok_ok;
        d.tok_ref   = TOKEN.valid && !tok_ok;
        d.tok_hshk  = TOKEN.valid && tok_ok && tok_ep[EP_HSHK_BIT];
        // host mode controls held in endpoint 0
        d.retry     = HOST_MODE && NAK_SEEN && !q.ep[0][EP_RDIS_BIT];
        d.ls_direct = HOST_MODE && q.ep[0][EP_LOW_SPEED_DIRECT_BIT];
        d.pre_pid   = HOST_MODE && !q.ep[0][EP_LOW_SPEED_DIRECT_BIT];
        // power and test controls
        d.halted    = q.cfg[CFG_SIDL_BIT] && CHIP_IDLE;
        d.susp      = susp_now;
        d.oe_mon    = q.cfg[CFG_OEM_BIT] && LINE_DRIVE;
        d.eye_run   = q.cfg[CFG_EYE_BIT];
    end

    // ==========================================
    // state register, everything zero at reset
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ==========================================
    // outputs
    assign ARREADY          = !q.rvalid;
    assign BVALID           = q.bvalid;
    assign BRESP            = q.bresp;
    assign RVALID           = q.rvalid;
    assign RDATA            = q.rdata;
    assign RRESP            = q.rresp;
    assign TOK_ACCEPT       = q.tok_acc;
    assign TOK_REFUSE       = q.tok_ref;
    assign TOK_HANDSHAKE    = q.tok_hshk;
    assign NAK_RETRY        = q.retry;
    assign LOW_SPEED_DIRECT = q.ls_direct;
    assign PRE_PID_REQ      = q.pre_pid;
    assign EYE_TEST_RUN     = q.eye_run;
    assign OE_MON_B         = !q.oe_mon;  // active low monitor
    assign MODULE_HALT      = q.halted;
    assign USB_SUSPEND      = q.susp;
    assign CLK48_EN         = !q.susp;  // 48 MHz clock gated by suspend
    assign IRQ              = |(q.irq_sts & q.irq_en);

    // ==========================================
    // checks
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_B);

    sequence s_tok(usbec_tok_kind_t k);
        TOKEN.valid && TOKEN.kind == k;
    endsequence

    property p_eye;
        q.cfg[CFG_EYE_BIT] |=> EYE_TEST_RUN;
    endproperty
    a_eye: assert property (p_eye) else $error("eye test not running");

    property p_oe_mon;
        LINE_DRIVE && q.cfg[CFG_OEM_BIT] |=> !OE_MON_B;
    endproperty
    a_oe_mon: assert property (p_oe_mon) else $error("oe monitor missing");

    property p_halt;
        CHIP_IDLE && q.cfg[CFG_SIDL_BIT] |=> MODULE_HALT ##1 !TOK_ACCEPT;
    endproperty
    a_halt: assert property (p_halt) else $error("idle halt missed");

    property p_auto_susp;
        CHIP_SLEEP && q.cfg[CFG_ASUS_BIT] |=> USB_SUSPEND && !CLK48_EN;
    endproperty
    a_auto_susp: assert property (p_auto_susp) else $error("auto suspend missed");

    property p_no_auto;
        !q.cfg[CFG_ASUS_BIT] && !q.sw_susp |=> !USB_SUSPEND;
    endproperty
    a_no_auto: assert property (p_no_auto) else $error("unexpected suspend");

    property p_upper_zero;
        RVALID && $past(ARADDR[7:6]) == EP_PAGE |-> RDATA[31:8] == 24'h00_0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");

    property p_low_speed_direct;
        HOST_MODE && q.ep[0][EP_LOW_SPEED_DIRECT_BIT] |=> LOW_SPEED_DIRECT && !PRE_PID_REQ;
    endproperty
    a_low_speed_direct: assert property (p_low_speed_direct) else $error("low speed select wrong");

    property p_retry;
        HOST_MODE && NAK_SEEN |=> NAK_RETRY == !$past(q.ep[0][EP_RDIS_BIT]);
    endproperty
    a_retry: assert property (p_retry) else $error("nak retry wrong");

    property p_setup_off;
        s_tok(USBEC_TOK_SETUP) ##0 (tok_ep[EP_CDIS_BIT] && tok_ep[EP_TXEN_BIT]
                                    && tok_ep[EP_RXEN_BIT]) |=> TOK_REFUSE;
    endproperty
    a_setup_off: assert property (p_setup_off) else $error("setup not refused");

    property p_rx_off;
        s_tok(USBEC_TOK_OUT) ##0 !tok_ep[EP_RXEN_BIT] |=> TOK_REFUSE && !TOK_ACCEPT;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("rx accepted while off");

    property p_tx_off;
        s_tok(USBEC_TOK_IN) ##0 !tok_ep[EP_TXEN_BIT] |=> TOK_REFUSE && !TOK_ACCEPT;
    endproperty
    a_tx_off: assert property (p_tx_off) else $error("tx while off");

    property p_stall;
        STALL_SET[NUM_EP-1] |=> q.ep[NUM_EP-1][EP_STAL_BIT] && q.irq_sts[IRQ_STALL];
    endproperty
    a_stall: assert property (p_stall) else $error("stall not recorded");

    property p_hshk;
        TOK_HANDSHAKE |-> TOK_ACCEPT && $past(tok_ep[EP_HSHK_BIT]);
    endproperty
    a_hshk: assert property (p_hshk) else $error("handshake while off");

    property p_mask;
        (q.cfg & ~CFG_MASK) == 8'h00 && (q.ep[0] & ~EP_MASK) == 8'h00;
    endproperty
    a_mask: assert property (p_mask) else $error("unimplemented bit set");

    property p_eye_off;
        !q.cfg[CFG_EYE_BIT] |=> !EYE_TEST_RUN;
    endproperty
    a_eye_off: assert property (p_eye_off) else $error("eye test left running");

    property p_oe_off;
        !q.cfg[CFG_OEM_BIT] |=> OE_MON_B;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("oe monitor active while off");

    property p_stall_refuse;
        TOKEN.valid && tok_ep[EP_STAL_BIT] |=> TOK_REFUSE && !TOK_HANDSHAKE;
    endproperty
    a_stall_refuse: assert property (p_stall_refuse) else $error("stall not refused");

    property p_no_hshk;
        TOKEN.valid && !tok_ep[EP_HSHK_BIT] |=> !TOK_HANDSHAKE;
    endproperty
    a_no_hshk: assert property (p_no_hshk) else $error("handshake while disabled");

    property p_susp_irq;
        susp_now && !USB_SUSPEND |=> q.irq_sts[IRQ_SUSPEND];
    endproperty
    a_susp_irq: assert property (p_susp_irq) else $error("suspend event lost");

    property p_refuse_irq;
        TOKEN.valid && !tok_ok |=> q.irq_sts[IRQ_REFUSE];
    endproperty
    a_refuse_irq: assert property (p_refuse_irq) else $error("refusal not recorded");

endmodule

// ==== logic/usbec_pkg.sv ====
package usbec_pkg;

    // ==========================================
    // bus geometry
    localparam int          AXI_ADDR_W   = 8;
    localparam int          NUM_EP       = 16;
    localparam int          IRQ_W        = 3;

    // ==========================================
    // register byte offsets
    localparam logic [7:0]  OFS_CONFIG   = 8'h00;  // config_one_register
    localparam logic [7:0]  OFS_POWER    = 8'h04;  // power_control_register
    localparam logic [7:0]  OFS_IRQ_STS  = 8'h08;  // sticky event status, read only
    localparam logic [7:0]  OFS_IRQ_EN   = 8'h0c;  // event enable
    localparam logic [7:0]  OFS_IRQ_CLR  = 8'h10;  // write one to clear, reads zero
    localparam logic [7:0]  OFS_EP_BASE  = 8'h40;  // endpoint_control_registers 0..15
    localparam logic [1:0]  EP_PAGE      = 2'h1;   // addr[7:6] of the endpoint block

    // ==========================================
    // config_one_register fields
    localparam int          CFG_EYE_BIT  = 7;      // eye_test_enable
    localparam int          CFG_OEM_BIT  = 6;      // output_enable_monitor
    localparam int          CFG_SIDL_BIT = 4;      // halt_when_idle
    localparam int          CFG_ASUS_BIT = 0;      // auto_sleep_suspend
    localparam logic [7:0]  CFG_MASK     = 8'hd1;
    localparam int          PWR_SUSP_BIT = 1;      // software_suspend
    localparam logic [7:0]  PWR_MASK     = 8'h02;

    // ==========================================
    // endpoint_control_registers fields
    localparam int          EP_LOW_SPEED_DIRECT_BIT  = 7;      // low_speed_direct
    localparam int          EP_RDIS_BIT  = 6;      // nak_retry_disable
    localparam int          EP_CDIS_BIT  = 4;      // control_transfer_disable
    localparam int          EP_RXEN_BIT  = 3;      // endpoint_receive_enable
    localparam int          EP_TXEN_BIT  = 2;      // endpoint_transmit_enable
    localparam int          EP_STAL_BIT  = 1;      // endpoint_stalled
    localparam int          EP_HSHK_BIT  = 0;      // endpoint_handshake_enable
    localparam logic [7:0]  EP_MASK      = 8'hdf;

    // ==========================================
    // interrupt event bits
    localparam int          IRQ_STALL    = 0;
    localparam int          IRQ_REFUSE   = 1;
    localparam int          IRQ_SUSPEND  = 2;

    // ==========================================
    // axi responses and reset value
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    localparam logic [7:0]  REG_RESET    = 8'h00;

    // ==========================================
    // token kinds offered by the serial engine
    typedef enum logic [1:0] {
        USBEC_TOK_OUT,
        USBEC_TOK_IN,
        USBEC_TOK_SETUP,
        USBEC_TOK_NONE
    } usbec_tok_kind_t;

    typedef struct packed {
        logic            valid;
        usbec_tok_kind_t kind;
        logic [3:0]      ep;
    } usbec_tok_t;

    // ==========================================
    // whole block state
    typedef struct packed {
        logic [7:0]                 cfg;
        logic                       sw_susp;
        logic [NUM_EP-1:0][7:0]     ep;
        logic [IRQ_W-1:0]           irq_sts;
        logic [IRQ_W-1:0]           irq_en;
        logic                       aw_got;
        logic [AXI_ADDR_W-1:0]      awaddr;
        logic                       w_got;
        logic [7:0]                 wdata;
        logic                       wstrb0;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       rvalid;
        logic [31:0]                rdata;
        logic [1:0]                 rresp;
        logic                       tok_acc;
        logic                       tok_ref;
        logic                       tok_hshk;
        logic                       retry;
        logic                       halted;
        logic                       susp;
        logic                       oe_mon;
        logic                       eye_run;
        logic                       ls_direct;
        logic                       pre_pid;
    } usbec_state_t;

endpackage

// ==== test/usbec_bus_model.sv ====
`timescale 1ns/10ps

module usbec_bus_model
    import usbec_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire usbec_tok_t cmd,
    output usbec_tok_t      token
);

    // ==========================================
    // token launch toward the block
    // one token per valid cycle, back to back allowed; while idle the
    // endpoint field keeps changing so a stale value never looks valid
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            token <= '{valid: 1'b0, kind: USBEC_TOK_NONE, ep: 4'h0};
        end else if (cmd.valid) begin
            token <= cmd;
        end else begin
            token <= '{valid: 1'b0, kind: USBEC_TOK_NONE, ep: token.ep + 4'h5};
        end
    end

endmodule

// ==== test/usbec_ctrl_test.sv ====
`timescale 1ns/10ps

module usbec_ctrl_test
    import usbec_pkg::*;
;

    // ==========================================
    // signals
    logic        clk = 1'b0, rst_b, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, line_drive, host_mode;
    logic        nak_seen, chip_idle, chip_sleep, tok_accept, tok_refuse, tok_hshk;
    logic        nak_retry, ls_direct, pre_pid, eye_run, oe_mon_b, mod_halt;
    logic        usb_susp, clk48_en, irq, halt_x;
    logic [7:0]  awaddr, araddr, ep_sh [NUM_EP];
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [15:0] stall_set;
    logic [33:0] rd_q [$];
    logic [2:0]  tk_q [$];
    usbec_tok_t  cmd, token;
    int          fail_count, checks, seed, i;

    always #10 clk = ~clk;

    usbec_ctrl u_dut (
        .CORE_CLK(clk), .RST_B(rst_b), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
        .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
        .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .TOKEN(token),
        .STALL_SET(stall_set), .LINE_DRIVE(line_drive), .HOST_MODE(host_mode),
        .NAK_SEEN(nak_seen), .CHIP_IDLE(chip_idle), .CHIP_SLEEP(chip_sleep),
        .TOK_ACCEPT(tok_accept), .TOK_REFUSE(tok_refuse), .TOK_HANDSHAKE(tok_hshk),
        .NAK_RETRY(nak_retry), .LOW_SPEED_DIRECT(ls_direct), .PRE_PID_REQ(pre_pid),
        .EYE_TEST_RUN(eye_run), .OE_MON_B(oe_mon_b), .MODULE_HALT(mod_halt),
        .USB_SUSPEND(usb_susp), .CLK48_EN(clk48_en), .IRQ(irq)
    );

    usbec_bus_model u_bus (.clk(clk), .rst_b(rst_b), .cmd(cmd), .token(token));

    // ==========================================
    // helpers
    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic [7:0] epa(input int n);
        return OFS_EP_BASE + 8'(4 * n);
    endfunction

    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        logic ta, tw, tb;
        tb = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!tb) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            if (tb) chk("bresp", er, bresp);
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
    endtask

    // read: expected word noted, the monitor compares it
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        logic ta, tr;
        tr = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rd_q.push_back(e);
        while (!tr) begin
            @(negedge clk);
            ta = arvalid && arready;
            tr = rvalid;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
        end
    endtask

    // token: verdict worked out from the shadow endpoint bits
    task automatic tok(input logic [1:0] k, input logic [3:0] e);
        logic [7:0] r;
        logic ok;
        r = ep_sh[e];
        case (k)
            2'h0: ok = r[3];
            2'h1: ok = r[2];
            default: ok = r[3] && !(r[2] && r[3] && r[4]);
        endcase
        ok = ok && !r[1] && !halt_x;
        tk_q.push_back({ok, !ok, ok && r[0]});
        @(posedge clk);
        cmd <= '{valid: 1'b1, kind: usbec_tok_kind_t'(k), ep: e};
    endtask

    task automatic settle();
        @(posedge clk);
        cmd.valid <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================
    // monitor: oldest note against each result
    always @(negedge clk) begin
        if (rvalid && rready) chk("rdata", rd_q.pop_front(), {rresp, rdata});
        if (tok_accept || tok_refuse || tok_hshk) begin
            chk("token", tk_q.pop_front(), {tok_accept, tok_refuse, tok_hshk});
        end
    end

    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end

    // ==========================================
    // main sequence
    initial begin
        seed = 32'h60ea45ae;
        {rst_b, awvalid, wvalid, arvalid, nak_seen, halt_x} = '0;
        {line_drive, host_mode, chip_idle, chip_sleep, awaddr, araddr} = '0;
        {bready, rready, wstrb, wdata, stall_set, cmd} = {2'h3, 4'hf, 55'h0};
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        // reset values, unmapped place
        rd(OFS_CONFIG, 34'h0);
        rd(OFS_POWER, 34'h0);
        for (i = 0; i < NUM_EP; i++) rd(epa(i), 34'h0);
        rd(8'h20, {RESP_SLVERR, 32'h0});
        wr(8'h20, 32'hff, RESP_SLVERR);
        // random endpoint contents with the upper bits set
        for (i = 0; i < NUM_EP; i++) begin
            d = $random(seed) | 32'hffffff00;
            wr(epa(i), d, RESP_OKAY);
            ep_sh[i] = d[7:0] & EP_MASK;
        end
        for (i = 0; i < NUM_EP; i++) rd(epa(i), {26'h0, ep_sh[i]});
        // back-to-back random tokens
        for (i = 0; i < 60; i++) tok(2'($unsigned($random(seed)) % 3), 4'($random(seed)));
        settle();
        // control disable with both directions on, then rx only, then off
        wr(epa(5), 32'h1d, RESP_OKAY);
        ep_sh[5] = 8'h1d;
        wr(epa(6), 32'h18, RESP_OKAY);
        ep_sh[6] = 8'h18;
        for (i = 0; i < 3; i++) tok(2'(i), 4'h5);
        for (i = 0; i < 3; i++) tok(2'(i), 4'h6);
        settle();
        wr(epa(5), 32'h0d, RESP_OKAY);
        ep_sh[5] = 8'h0d;
        tok(2'h2, 4'h5);
        settle();
        // hardware stall shows in the register and refuses tokens
        @(posedge clk);
        stall_set <= 16'h8020;
        @(posedge clk);
        stall_set <= 16'h0000;
        ep_sh[5][1] = 1'b1;
        ep_sh[15][1] = 1'b1;
        rd(epa(5), {26'h0, ep_sh[5]});
        rd(epa(15), {26'h0, ep_sh[15]});
        tok(2'h0, 4'h5);
        settle();
        // configuration bits all set
        wr(OFS_CONFIG, 32'hffffffff, RESP_OKAY);
        rd(OFS_CONFIG, {26'h0, CFG_MASK});
        @(posedge clk);
        {line_drive, chip_idle, chip_sleep} <= 3'h7;
        halt_x = 1'b1;
        settle();
        chk("eye_run", 1'b1, eye_run);
        chk("oe_mon_b", 1'b0, oe_mon_b);
        chk("mod_halt", 1'b1, mod_halt);
        chk("usb_susp", 1'b1, usb_susp);
        chk("clk48_en", 1'b0, clk48_en);
        @(posedge clk);
        chip_sleep <= 1'b0;
        settle();
        tok(2'h0, 4'h6);
        settle();
        @(posedge clk);
        chip_sleep <= 1'b1;
        // configuration cleared, chip still idle and asleep
        wr(OFS_CONFIG, 32'h0, RESP_OKAY);
        halt_x = 1'b0;
        settle();
        chk("eye_run", 1'b0, eye_run);
        chk("oe_mon_b", 1'b1, oe_mon_b);
        chk("mod_halt", 1'b0, mod_halt);
        chk("usb_susp", 1'b0, usb_susp);
        tok(2'h0, 4'h6);
        settle();
        wr(OFS_POWER, 32'hffffffff, RESP_OKAY);
        rd(OFS_POWER, {26'h0, PWR_MASK});
        settle();
        chk("usb_susp", 1'b1, usb_susp);
        chk("clk48_en", 1'b0, clk48_en);
        wr(OFS_POWER, 32'h0, RESP_OKAY);
        // host mode options of endpoint 0
        @(posedge clk);
        host_mode <= 1'b1;
        for (i = 0; i < 2; i++) begin
            d = i ? 32'h40 : 32'h80;
            wr(epa(0), d, RESP_OKAY);
            settle();
            chk("ls_direct", d[7], ls_direct);
            chk("pre_pid", !d[7], pre_pid);
            @(posedge clk);
            nak_seen <= 1'b1;
            @(posedge clk);
            nak_seen <= 1'b0;
            @(negedge clk);
            chk("nak_retry", !d[6], nak_retry);
        end
        // interrupt: raise, mask, unmask, clear
        wr(OFS_IRQ_CLR, 32'h7, RESP_OKAY);
        wr(OFS_IRQ_EN, 32'h2, RESP_OKAY);
        tok(2'h1, 4'h6);
        settle();
        chk("irq", 1'b1, irq);
        rd(OFS_IRQ_STS, 34'h2);
        wr(OFS_IRQ_EN, 32'h0, RESP_OKAY);
        chk("irq", 1'b0, irq);
        wr(OFS_IRQ_EN, 32'h2, RESP_OKAY);
        chk("irq", 1'b1, irq);
        wr(OFS_IRQ_CLR, 32'h2, RESP_OKAY);
        settle();
        chk("irq", 1'b0, irq);
        rd(OFS_IRQ_STS, 34'h0);
        settle();
        chk("pending", 34'h0, 34'(rd_q.size() + tk_q.size()));
        tally_and_finish();
    end

endmodule
